// ### hdl/homing_reference_sequencer.sv
/*
 Homing reference sequencer with its register slave and interrupt logic.
 Assumes switch, index and standstill inputs synchronous to clk, and a
 motion profiler downstream that ramps the velocity command it is given.
*/
`timescale 1ns/1ps
`default_nettype none
module homing_reference_sequencer #(
   parameter int unsigned POS_W = 32
) (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 ce,
   input  wire logic [3:0]           addr,
   input  wire logic [31:0]          wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic      [31:0]          rdata,
   output logic                      irq,
   input  wire logic                 lim_neg,
   input  wire logic                 lim_pos,
   input  wire logic                 ref_sw,
   input  wire logic                 index_pulse,
   input  wire logic                 standstill,
   input  wire logic                 quick_stop,
   input  wire logic                 fault,
   input  wire logic [POS_W-1:0]     act_pos,
   output logic                      move_en,
   output logic                      move_dir,
   output logic      [15:0]          move_speed,
   output logic      [15:0]          move_accel,
   output logic                      pos_load,
   output logic      [POS_W-1:0]     pos_load_val,
   output logic      [POS_W-1:0]     origin,
   output logic                      homed
);
   // Positions wider than the bus word could not be read back in one go.
   if (POS_W < 16 || POS_W > 32) begin : g_bad_pos_w
      $error("POS_W must be 16..32");
   end

   localparam int unsigned EV_W_L = homing_pkg::EV_W;
   homing_pkg::hstate_e st_q, st_d;
   logic [7:0]       method_q;
   logic [15:0]      spd_sw_q, spd_idx_q, accel_q;
   logic [POS_W-1:0] refpos_q, offset_q, dist_q, mark_q, origin_q;
   logic             valid_q, abort_q, halt_q, dir_q;
   logic [EV_W_L-1:0] ev_q, mask_q;
   logic [9:0]       still_q;
   logic [31:0]      rdata_q;

   function automatic logic in_rng(input logic [7:0] m, input logic [7:0] lo,
                                   input logic [7:0] hi);
      in_rng = (m >= lo) && (m <= hi);
   endfunction : in_rng

   wire wr_ctrl  = wr && addr == homing_pkg::A_CTRL;
   wire start    = ce && wr_ctrl && wdata[homing_pkg::C_START];
   wire legal    = in_rng(method_q, homing_pkg::M_MIN, homing_pkg::M_MAX);
   wire is_lim   = in_rng(method_q, homing_pkg::M_LIM_NEG,
                          homing_pkg::M_LIM_POSD);
   wire is_ref   = in_rng(method_q, homing_pkg::M_REF_DIST,
                          homing_pkg::M_REF_LAST);
   wire is_set   = method_q == homing_pkg::M_SET;
   // Odd codes search in the negative direction, even codes positive.
   wire neg_dir  = method_q[0];
   wire use_dist = method_q == homing_pkg::M_LIM_NEGD ||
                   method_q == homing_pkg::M_LIM_POSD ||
                   method_q == homing_pkg::M_REF_DIST;
   wire sw_hit   = is_lim ? (neg_dir ? lim_neg : lim_pos) : ref_sw;
   wire stop_req = halt_q || quick_stop || fault;
   wire [POS_W-1:0] travel = act_pos - mark_q;
   wire dist_done = (dir_q ? (mark_q - act_pos) : travel) >= dist_q;
   wire still_ok = standstill && still_q >= 10'(homing_pkg::STILL_CYC);
   wire busy     = st_q != homing_pkg::ST_IDLE;
   wire [EV_W_L-1:0] ev_set;
   wire rd_ev    = ce && rd && addr == homing_pkg::A_EVENTS;

   assign ev_set[homing_pkg::E_DONE]  = st_q == homing_pkg::ST_SETTL &&
                                        still_ok && ce;
   assign ev_set[homing_pkg::E_ABORT] = st_q == homing_pkg::ST_ABORT &&
                                        still_ok && ce;

   always_comb begin
      st_d = st_q;
      case (st_q)
         homing_pkg::ST_IDLE:
            if (start && legal) begin
               st_d = is_set ? homing_pkg::ST_SETTL :
                      (is_lim || is_ref) ? homing_pkg::ST_SEEK :
                      homing_pkg::ST_FINAL;
            end
         homing_pkg::ST_SEEK:
            if (sw_hit) begin
               st_d = homing_pkg::ST_STOP;
            end
         homing_pkg::ST_STOP:
            if (standstill) begin
               st_d = homing_pkg::ST_BACK;
            end
         homing_pkg::ST_BACK:
            if (!sw_hit) begin
               st_d = homing_pkg::ST_FINAL;
            end
         homing_pkg::ST_FINAL:
            if (use_dist ? dist_done : index_pulse) begin
               st_d = homing_pkg::ST_SETTL;
            end
         homing_pkg::ST_SETTL:
            if (still_ok) begin
               st_d = homing_pkg::ST_IDLE;
            end
         homing_pkg::ST_ABORT:
            if (still_ok) begin
               st_d = homing_pkg::ST_IDLE;
            end
         default: st_d = homing_pkg::ST_IDLE;
      endcase
      // A stop cause that is still held must not keep the stop from
      // ending once the motor has come to rest.
      if (busy && st_q != homing_pkg::ST_SETTL &&
          st_q != homing_pkg::ST_ABORT && stop_req) begin
         st_d = homing_pkg::ST_ABORT;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= homing_pkg::ST_IDLE;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // Standstill is counted so that a brief zero crossing is not taken
   // as the end of the move.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         still_q <= '0;
      end else if (ce) begin
         still_q <= (!standstill || st_d != st_q) ? '0 :
                    still_ok ? still_q : still_q + 10'h001;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mark_q <= '0;
         dir_q  <= 1'b0;
      end else if (ce && st_q != homing_pkg::ST_FINAL &&
                   st_d == homing_pkg::ST_FINAL) begin
         mark_q <= act_pos;
         dir_q  <= is_lim || is_ref ? ~neg_dir : neg_dir;
      end
   end

   // Position captured at the reference point as origin; refpos_q plus the offset is loaded.
   wire capture = ce && st_q != homing_pkg::ST_SETTL &&
                  st_d == homing_pkg::ST_SETTL;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         valid_q  <= 1'b0;
         origin_q <= '0;
         pos_load <= 1'b0;
         pos_load_val <= '0;
      end else if (ce) begin
         pos_load <= capture;
         if (capture) begin
            pos_load_val <= refpos_q + offset_q;
            origin_q <= act_pos;
            valid_q <= 1'b0;
         end else if (st_q == homing_pkg::ST_SETTL && still_ok) begin
            valid_q <= 1'b1;
         end else if (start) begin
            valid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         abort_q <= 1'b0;
      end else if (ce) begin
         if (st_d == homing_pkg::ST_ABORT) begin
            abort_q <= 1'b1;
         end else if (start) begin
            abort_q <= 1'b0;
         end
      end
   end

   // Motion command; the profiler ramps it with the homing acceleration.
   always_comb begin
      move_en  = st_q == homing_pkg::ST_SEEK ||
                 st_q == homing_pkg::ST_BACK ||
                 st_q == homing_pkg::ST_FINAL;
      // High means a negative move; the return leg runs against the seek.
      move_dir = st_q == homing_pkg::ST_SEEK ? neg_dir :
                 st_q == homing_pkg::ST_BACK ? ~neg_dir : dir_q;
      move_speed = st_q == homing_pkg::ST_FINAL ? spd_idx_q : spd_sw_q;
   end
   assign move_accel = accel_q;
   assign origin = origin_q;
   assign homed  = valid_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         method_q  <= homing_pkg::M_MIN;
         spd_sw_q  <= homing_pkg::SPD_SW_RST;
         spd_idx_q <= homing_pkg::SPD_IDX_RST;
         accel_q   <= homing_pkg::ACCEL_RST;
         refpos_q  <= '0;
         offset_q  <= '0;
         dist_q    <= '0;
         mask_q    <= '0;
         halt_q    <= 1'b0;
      end else if (ce && wr) begin
         case (addr)
            homing_pkg::A_CTRL:    halt_q    <= wdata[homing_pkg::C_HALT];
            homing_pkg::A_METHOD:  method_q  <= wdata[7:0];
            homing_pkg::A_SPD_SW:  spd_sw_q  <= wdata[15:0];
            homing_pkg::A_SPD_IDX: spd_idx_q <= wdata[15:0];
            homing_pkg::A_ACCEL:   accel_q   <= wdata[15:0];
            homing_pkg::A_REFPOS:  refpos_q  <= wdata[POS_W-1:0];
            homing_pkg::A_OFFSET:  offset_q  <= wdata[POS_W-1:0];
            homing_pkg::A_DIST:    dist_q    <= wdata[POS_W-1:0];
            homing_pkg::A_MASK:    mask_q    <= wdata[EV_W_L-1:0];
            default: ;
         endcase
      end
   end

   // A new event in the reading cycle survives the clear.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ev_q <= '0;
      end else if (ce) begin
         ev_q <= (rd_ev ? '0 : ev_q) | ev_set;
      end
   end
   assign irq = |(ev_q & mask_q);

   wire [31:0] stat = {29'h0, abort_q, valid_q, busy};
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= '0;
      end else if (ce) begin
         case (addr)
            homing_pkg::A_METHOD:  rdata_q <= {24'h0, method_q};
            homing_pkg::A_SPD_SW:  rdata_q <= {16'h0, spd_sw_q};
            homing_pkg::A_SPD_IDX: rdata_q <= {16'h0, spd_idx_q};
            homing_pkg::A_ACCEL:   rdata_q <= {16'h0, accel_q};
            homing_pkg::A_REFPOS:  rdata_q <= 32'(refpos_q);
            homing_pkg::A_OFFSET:  rdata_q <= 32'(offset_q);
            homing_pkg::A_DIST:    rdata_q <= 32'(dist_q);
            homing_pkg::A_STATUS:  rdata_q <= stat;
            homing_pkg::A_EVENTS:  rdata_q <= 32'(ev_q);
            homing_pkg::A_MASK:    rdata_q <= 32'(mask_q);
            homing_pkg::A_ORIGIN:  rdata_q <= 32'(origin_q);
            default:               rdata_q <= '0;
         endcase
      end
   end
   assign rdata = rdata_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_done; st_q == homing_pkg::ST_SETTL && still_ok && ce; endsequence
   sequence s_abrt; st_q == homing_pkg::ST_ABORT; endsequence

   a_valid_on_done: assert property (s_done |=> valid_q)
      else $error("zero point not valid after success");
   a_valid_cause: assert property ($rose(valid_q) |-> $past(st_q) ==
      homing_pkg::ST_SETTL) else $error("valid without success");
   a_abort_no_valid: assert property (s_abrt |-> !valid_q)
      else $error("valid during abort");
   a_end_still: assert property ($fell(busy) |-> $past(standstill))
      else $error("ended while moving");
   a_illegal_ign: assert property (!busy && start && !legal |=> !busy)
      else $error("illegal method started");
   a_start_busy: assert property (!busy && start && legal |=> busy)
      else $error("start not taken");
   a_set_nomove: assert property (busy && is_set |-> !move_en)
      else $error("set method moved");
   a_idx_speed: assert property (st_q == homing_pkg::ST_FINAL |->
      move_speed == spd_idx_q) else $error("wrong index speed");
   a_stop_abort: assert property (busy && ce && stop_req &&
      st_q != homing_pkg::ST_SETTL && st_q != homing_pkg::ST_ABORT |=>
      st_q == homing_pkg::ST_ABORT) else $error("stop not honoured");
   a_flag_abort: assert property (s_abrt |-> abort_q)
      else $error("abort flag missing");

   // Each search step must advance on its own event unless a stop cause
   // is present, which takes the sequencer to its abort state instead.
   sequence s_seek_hit;
      st_q == homing_pkg::ST_SEEK && ce && sw_hit && !stop_req;
   endsequence
   sequence s_back_clear;
      st_q == homing_pkg::ST_BACK && ce && !sw_hit && !stop_req;
   endsequence
   sequence s_ref_found;
      st_q == homing_pkg::ST_FINAL && ce && !stop_req &&
      (use_dist ? dist_done : index_pulse);
   endsequence

   a_seek_stop: assert property (s_seek_hit |=>
      st_q == homing_pkg::ST_STOP) else $error("no stop at switch");
   a_stop_hold: assert property (st_q == homing_pkg::ST_STOP |->
      !move_en) else $error("moving while stopping");
   a_back_final: assert property (s_back_clear |=>
      st_q == homing_pkg::ST_FINAL) else $error("switching point missed");
   a_seek_dir: assert property (st_q == homing_pkg::ST_SEEK |->
      move_dir == method_q[0]) else $error("wrong seek direction");
   a_ref_capture: assert property (s_ref_found |=>
      st_q == homing_pkg::ST_SETTL && pos_load)
      else $error("reference point not taken");
   a_origin_cap: assert property (s_ref_found |=>
      origin_q == $past(act_pos)) else $error("origin not captured");
   a_load_val: assert property (pos_load |->
      pos_load_val == $past(refpos_q + offset_q))
      else $error("wrong position loaded");
   a_sw_speed: assert property (st_q == homing_pkg::ST_SEEK ||
      st_q == homing_pkg::ST_BACK |-> move_speed == spd_sw_q)
      else $error("wrong switch speed");
   a_abort_end: assert property ($fell(busy) &&
      $past(st_q) == homing_pkg::ST_ABORT |-> abort_q && !valid_q)
      else $error("abort ended with wrong flags");
endmodule : homing_reference_sequencer
`default_nettype wire

// ### hdl/homing_pkg.sv
/*
 Constants for the homing reference sequencer: register indices, field
 positions, reset values, method codes and timing figures.
 Assumes a 5 ns clock period (CLK_NS) for its timing figures.
*/
package homing_pkg;
   localparam int unsigned ADDR_W = 4;
   // Register indices.
   localparam logic [3:0] A_CTRL    = 4'h0;
   localparam logic [3:0] A_METHOD  = 4'h1;
   localparam logic [3:0] A_SPD_SW  = 4'h2;
   localparam logic [3:0] A_SPD_IDX = 4'h3;
   localparam logic [3:0] A_ACCEL   = 4'h4;
   localparam logic [3:0] A_REFPOS  = 4'h5;
   localparam logic [3:0] A_OFFSET  = 4'h6;
   localparam logic [3:0] A_DIST    = 4'h7;
   localparam logic [3:0] A_STATUS  = 4'h8;
   localparam logic [3:0] A_EVENTS  = 4'h9;
   localparam logic [3:0] A_MASK    = 4'hA;
   localparam logic [3:0] A_ORIGIN  = 4'hB;
   // Control register bits.
   localparam int unsigned C_START = 0;
   localparam int unsigned C_HALT  = 1;
   // Status register bits.
   localparam int unsigned S_BUSY  = 0;
   localparam int unsigned S_VALID = 1;
   localparam int unsigned S_ABORT = 2;
   // Event bits.
   localparam int unsigned E_DONE  = 0;
   localparam int unsigned E_ABORT = 1;
   localparam int unsigned EV_W    = 2;
   // Method codes; the legal range and the groups within it.
   localparam logic [7:0] M_MIN      = 8'h01;
   localparam logic [7:0] M_MAX      = 8'h23;
   localparam logic [7:0] M_LIM_NEG  = 8'h01;
   localparam logic [7:0] M_LIM_POS  = 8'h02;
   localparam logic [7:0] M_LIM_NEGD = 8'h11;
   localparam logic [7:0] M_LIM_POSD = 8'h12;
   localparam logic [7:0] M_REF_DIST = 8'h13;
   localparam logic [7:0] M_REF_LAST = 8'h1E;
   localparam logic [7:0] M_IDX_NEG  = 8'h21;
   localparam logic [7:0] M_IDX_POS  = 8'h22;
   localparam logic [7:0] M_SET      = 8'h23;
   // Reset value of the motion speeds, in 0.1 rpm steps, and of the acceleration.
   localparam logic [15:0] SPD_SW_RST  = 16'h03E8;
   localparam logic [15:0] SPD_IDX_RST = 16'h0064;
   localparam logic [15:0] ACCEL_RST   = 16'h1000;
   // Standstill must hold this long before a sequence may end.
   localparam int unsigned STILL_NS = 1000;
   localparam int unsigned CLK_NS   = 5;
   localparam int unsigned STILL_CYC = (STILL_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SEEK  = 3'b001,
      ST_STOP  = 3'b011,
      ST_BACK  = 3'b010,
      ST_FINAL = 3'b110,
      ST_SETTL = 3'b111,
      ST_ABORT = 3'b101
   } hstate_e;
endpackage : homing_pkg

// ### tb/motion_partner.sv
/*
 Behavioural motor, encoder and switch model facing the homing sequencer.
 Assumes move_dir high means a negative move, one step per clock.
*/
`timescale 1ns/1ps
`default_nettype none
module motion_partner #(
   parameter int POS_W  = 32,
   parameter int LAG    = 8,
   parameter int LIM_AT = 300,
   parameter int REF_AT = 100
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             move_en,
   input  wire logic             move_dir,
   input  wire logic             pos_load,
   input  wire logic [POS_W-1:0] pos_load_val,
   output logic                  lim_neg,
   output logic                  lim_pos,
   output logic                  ref_sw,
   output logic                  index_pulse,
   output logic                  standstill,
   output logic      [POS_W-1:0] act_pos
);
   logic signed [POS_W-1:0] pos_q;
   int                      lag_q;

   // Standstill trails the last motion, so the drive meets a slow stop.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pos_q <= '0;
         lag_q <= LAG;
      end else begin
         if (pos_load) begin
            pos_q <= pos_load_val;
         end else if (move_en) begin
            pos_q <= move_dir ? pos_q - 1 : pos_q + 1;
         end
         lag_q <= move_en ? 0 : (lag_q < LAG ? lag_q + 1 : lag_q);
      end
   end

   assign act_pos     = pos_q;
   assign standstill  = !move_en && lag_q == LAG;
   assign index_pulse = move_en && pos_q[5:0] == 6'h00;
   assign lim_neg     = pos_q <= -LIM_AT;
   assign lim_pos     = pos_q >= LIM_AT;
   // The reference cam shows on both sides, so either seek direction meets it.
   assign ref_sw      = pos_q >= REF_AT || pos_q <= -REF_AT;
endmodule : motion_partner
`default_nettype wire

// ### tb/tb_homing_reference_sequencer.sv
/*
 Self-checking bench for the homing sequencer and its motion partner.
 Assumes the register map and method codes of homing_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_homing_reference_sequencer;
   logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
   logic        quick_stop = 1'b0, fault = 1'b0, ce = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, act_pos, pos_load_val, origin;
   logic [31:0] pl_val, v;
   logic [15:0] move_speed, move_accel, spd_seen, acc_seen;
   logic        irq, lim_neg, lim_pos, ref_sw, index_pulse, standstill;
   logic        move_en, move_dir, pos_load, homed;
   logic        saw_neg, saw_pos, moved, pl_seen;
   logic [2:0]  saw_sw;
   int          n_fail = 0, checks_done = 0;

   always #2.5 clk = ~clk;

   homing_reference_sequencer u_dut (
      .clk, .nrst, .ce, .addr, .wdata, .wr, .rd, .rdata, .irq,
      .lim_neg, .lim_pos, .ref_sw, .index_pulse, .standstill,
      .quick_stop, .fault, .act_pos, .move_en, .move_dir, .move_speed,
      .move_accel, .pos_load, .pos_load_val, .origin, .homed);

   motion_partner u_motor (
      .clk, .nrst, .move_en, .move_dir, .pos_load, .pos_load_val,
      .lim_neg, .lim_pos, .ref_sw, .index_pulse, .standstill, .act_pos);

   always @(posedge clk) begin
      if (move_en && !moved) begin
         spd_seen <= move_speed;
         acc_seen <= move_accel;
      end
      if (move_en) begin
         moved <= 1'b1;
         if (move_dir) saw_neg <= 1'b1;
         else saw_pos <= 1'b1;
      end
      saw_sw <= saw_sw | {ref_sw, lim_pos, lim_neg};
      if (pos_load) begin
         pl_seen <= 1'b1;
         pl_val  <= pos_load_val;
      end
   end

   task automatic chk(input string n, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic final_report;
      if (n_fail == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      @(posedge clk);
   endtask : wreg

   task automatic rreg(input logic [3:0] a, output logic [31:0] d);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask : rreg

   // A run that never ends is cut off here and judged as failed.
   task automatic start_wait(input logic [7:0] m);
      wreg(homing_pkg::A_METHOD, {24'h0, m});
      {saw_neg, saw_pos, moved, pl_seen, saw_sw} = 7'h00;
      wreg(homing_pkg::A_CTRL, 32'h1);
      for (int i = 0; i < 4000; i++) begin
         rreg(homing_pkg::A_STATUS, v);
         if (v[homing_pkg::S_BUSY] === 1'b0) return;
      end
      n_fail++;
      final_report();
   endtask : start_wait

   task automatic finish_run(input logic [31:0] st, ev, input logic ie);
      chk("standstill", 32'h1, {31'h0, standstill});
      rreg(homing_pkg::A_STATUS, v);
      chk("status", st, v);
      chk("homed", {31'h0, st[1]}, {31'h0, homed});
      chk("irq_set", {31'h0, ie}, {31'h0, irq});
      rreg(homing_pkg::A_EVENTS, v);
      chk("events", ev, v);
      chk("irq_clr", 32'h0, {31'h0, irq});
   endtask : finish_run

   task automatic t_reset;
      rreg(homing_pkg::A_STATUS, v);
      chk("status_rst", 32'h0, v);
      rreg(homing_pkg::A_METHOD, v);
      chk("method_rst", 32'h1, v);
      rreg(homing_pkg::A_SPD_SW, v);
      chk("spd_sw_rst", {16'h0, homing_pkg::SPD_SW_RST}, v);
      rreg(homing_pkg::A_SPD_IDX, v);
      chk("spd_idx_rst", {16'h0, homing_pkg::SPD_IDX_RST}, v);
      rreg(homing_pkg::A_ACCEL, v);
      chk("accel_rst", {16'h0, homing_pkg::ACCEL_RST}, v);
      rreg(4'hF, v);
      chk("unmapped", 32'h0, v);
      chk("homed_rst", 32'h0, {31'h0, homed});
   endtask : t_reset

   // A write made while the clock enable is low must leave no trace.
   task automatic t_freeze;
      ce <= 1'b0;
      wreg(homing_pkg::A_SPD_SW, 32'h0999);
      ce <= 1'b1;
      rreg(homing_pkg::A_SPD_SW, v);
      chk("ce_freeze", 32'h0123, v);
   endtask : t_freeze

   task automatic t_illegal;
      logic [7:0] bad [2];
      bad = '{8'h00, 8'h24};
      for (int i = 0; i < 2; i++) begin
         wreg(homing_pkg::A_METHOD, {24'h0, bad[i]});
         wreg(homing_pkg::A_CTRL, 32'h1);
         rreg(homing_pkg::A_STATUS, v);
         chk("illegal_busy", 32'h0, v);
      end
   endtask : t_illegal

   // Quick stop, fault and halt each cut a limit search short.
   task automatic t_abort;
      for (int k = 0; k < 3; k++) begin
         fork
            start_wait(8'h01);
            begin
               repeat (30) @(posedge clk);
               quick_stop <= (k == 0);
               fault      <= (k == 1);
               if (k == 2) force_halt();
            end
         join
         quick_stop <= 1'b0;
         fault      <= 1'b0;
         wreg(homing_pkg::A_CTRL, 32'h0);
         finish_run(32'h4, 32'h2, 1'b0);
      end
   endtask : t_abort

   // The halt bit is written between two status polls of the run.
   task automatic force_halt;
      @(negedge rd);
      wreg(homing_pkg::A_CTRL, 32'h2);
   endtask : force_halt

   task automatic t_set;
      wreg(homing_pkg::A_REFPOS, 32'h10);
      wreg(homing_pkg::A_OFFSET, 32'h5);
      start_wait(homing_pkg::M_SET);
      chk("load_seen", 32'h1, {31'h0, pl_seen});
      chk("load_val", 32'h15, pl_val);
      chk("moved", 32'h0, {31'h0, moved});
      finish_run(32'h2, 32'h1, 1'b1);
   endtask : t_set

   task automatic t_run(input logic [7:0] m, input logic r,
                        input logic [2:0] sw, input logic [15:0] spd);
      start_wait(m);
      chk("reverse", {31'h0, r}, {31'h0, saw_neg & saw_pos});
      chk("switch", {29'h0, sw}, {29'h0, saw_sw & sw});
      chk("speed", {16'h0, spd}, {16'h0, spd_seen});
      chk("accel", 32'h777, {16'h0, acc_seen});
      finish_run(32'h2, 32'h1, 1'b1);
   endtask : t_run

   // Index searches start from the set position, so the origin is known.
   task automatic t_index(input logic [7:0] m, input logic [31:0] org);
      t_run(m, 1'b0, 3'h0, 16'h0045);
      rreg(homing_pkg::A_ORIGIN, v);
      chk("origin", org, v);
   endtask : t_index

   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset();
      wreg(homing_pkg::A_SPD_SW, 32'h0123);
      wreg(homing_pkg::A_SPD_IDX, 32'h0045);
      wreg(homing_pkg::A_ACCEL, 32'h0777);
      wreg(homing_pkg::A_DIST, 32'h0020);
      wreg(homing_pkg::A_MASK, 32'h1);
      t_freeze();
      t_illegal();
      t_abort();
      wreg(homing_pkg::A_MASK, 32'h3);
      t_set();
      t_run(8'h14, 1'b1, 3'h4, 16'h0123);
      t_set();
      t_run(8'h13, 1'b1, 3'h4, 16'h0123);
      t_run(8'h01, 1'b1, 3'h1, 16'h0123);
      t_run(8'h02, 1'b1, 3'h2, 16'h0123);
      t_run(8'h11, 1'b1, 3'h1, 16'h0123);
      t_set();
      t_index(8'h21, 32'h0);
      t_index(8'h22, 32'h40);
      final_report();
   end
endmodule : tb_homing_reference_sequencer
`default_nettype wire
